// >>> hdl/serial_clock_edge_select.sv
// Purpose: Chooses the serial clock edges for input sampling and output update.
// Assumes: Chip select, frame sync and the invert pin are asynchronous to sys_clk.
// Notes: The mode is captured in the system domain and steers the link clock edges.
//
// Summary of operation
// RULE_01: Input bits clocked only by serial clock.
// RULE_02: Invert pin low inverts the input clock.
// RULE_03: Inversion delays sampling by half period.
// RULE_04: Inverted: output updates on the sampling edge.
// RULE_05: Microprocessor mode: output falls, pin-high samples rising.
// RULE_06: DSP mode: output rises, pin-high samples falling.
// RULE_07: Frame sync at chip-select fall sets mode.
// RULE_08: Host holds DSP frame sync one period.
// RULE_09: DSP host drops chip select, frame sync.
// RULE_10: Mode held until next chip-select fall.
`timescale 1ns/1ns
`default_nettype none
module serial_clock_edge_select
	import edge_select_pkg::*;
#(
	parameter int IN_W = IN_W_DEF,
	parameter int OUT_W = OUT_W_DEF
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic io_clk,
	input wire logic cs_n,
	input wire logic frame_sync,
	input wire logic clock_invert_pin,
	input wire logic data_in,
	input wire logic [OUT_W-1:0] tx_word,
	output logic data_out,
	output logic data_out_en,
	output logic [IN_W-1:0] rx_word,
	output logic rx_valid,
	output logic microprocessor_mode,
	output logic sample_on_falling
);
	typedef struct packed {
		logic cs_meta;
		logic cs_sync;
		logic cs_prev;
		logic fs_meta;
		logic fs_sync;
		logic inv_meta;
		logic inv_sync;
		logic mode;
		logic sample_inv;
		logic tog_meta;
		logic tog_sync;
		logic tog_prev;
		logic [IN_W-1:0] word;
		logic valid;
		logic oe;
		logic hold;
	} state_s;

	state_s q;
	state_s d;
	logic link_toggle;
	logic [IN_W-1:0] link_word;
	logic link_data;

	function automatic logic mode_of(input logic fs_level);
		return fs_level ? MODE_MP : MODE_DSP;
	endfunction

	// ----------------------------------------------------------------
	// Link side
	// ----------------------------------------------------------------
	serial_edge_shifter #(
		.IN_W(IN_W),
		.OUT_W(OUT_W)
	) link (
		.io_clk(io_clk),
		.sample_invert(q.sample_inv), // see RULE_02
		.update_invert(q.mode), // see RULE_05 see RULE_06
		.cs_n(q.hold),
		.reset(reset),
		.data_in(data_in),
		.tx_word(tx_word),
		.rx_word(link_word),
		.rx_toggle(link_toggle),
		.data_out(link_data)
	);

	// ----------------------------------------------------------------
	// System side
	// ----------------------------------------------------------------
	// The mode is sampled at the synchronised chip-select fall, so the host
	// must leave a few system clocks before its first serial edge.
	always_comb begin
		d = q;
		d.cs_meta = cs_n;
		d.cs_sync = q.cs_meta;
		d.cs_prev = q.cs_sync;
		d.fs_meta = frame_sync;
		d.fs_sync = q.fs_meta;
		d.inv_meta = clock_invert_pin;
		d.inv_sync = q.inv_meta;
		d.tog_meta = link_toggle;
		d.tog_sync = q.tog_meta;
		d.tog_prev = q.tog_sync;
		if (q.cs_prev && !q.cs_sync) begin
			d.mode = mode_of(q.fs_sync); // see RULE_07 see RULE_10
		end
		// The link stays cleared until one cycle after the selects settle, so a
		// select change on an idle serial clock cannot look like a clock edge.
		d.hold = q.cs_sync | q.cs_prev;
		// Edge selects only move while the link is held, never mid-frame.
		if (q.cs_sync && q.hold) begin
			d.sample_inv = q.mode ^ q.inv_sync; // see RULE_02 see RULE_05 see RULE_06
		end
		if (q.cs_prev && !q.cs_sync) begin
			d.sample_inv = mode_of(q.fs_sync) ^ q.inv_sync;
		end
		d.valid = q.tog_sync ^ q.tog_prev;
		if (q.tog_sync ^ q.tog_prev) begin
			d.word = link_word;
		end
		d.oe = ~q.cs_sync;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			q <= '0;
			q.cs_meta <= CS_IDLE;
			q.cs_sync <= CS_IDLE;
			q.cs_prev <= CS_IDLE;
			q.hold <= CS_IDLE;
			q.inv_meta <= INV_RESET;
			q.inv_sync <= INV_RESET;
			q.mode <= MODE_RESET;
			q.sample_inv <= MODE_RESET ^ INV_RESET;
		end else begin
			q <= d;
		end
	end

	assign data_out = link_data;
	assign data_out_en = q.oe;
	assign rx_word = q.word;
	assign rx_valid = q.valid;
	assign microprocessor_mode = q.mode;
	assign sample_on_falling = q.sample_inv;
endmodule
`default_nettype wire

// >>> shared/edge_select_pkg.sv
// Purpose: Shared constants for the serial clock edge selection block.
// Assumes: One system clock and one externally supplied serial I/O clock.
// Notes: Widths here are defaults only; the modules take them as parameters.
package edge_select_pkg;
	localparam int IN_W_DEF = 4;
	localparam int OUT_W_DEF = 10;
	localparam logic MODE_MP = 1'b1;
	localparam logic MODE_DSP = 1'b0;
	localparam logic MODE_RESET = 1'b1;
	localparam logic INV_RESET = 1'b1;
	localparam logic CS_IDLE = 1'b1;
endpackage

// >>> hdl/serial_edge_shifter.sv
// Purpose: Link-side shifters running on the serial I/O clock with selectable edges.
// Assumes: The edge selects and the transmit word are steady while chip select is low.
// Notes: Counters are cleared by chip select high, so nothing waits on a stopped clock.
`timescale 1ns/1ns
`default_nettype none
module serial_edge_shifter
	import edge_select_pkg::*;
#(
	parameter int IN_W = IN_W_DEF,
	parameter int OUT_W = OUT_W_DEF
) (
	input wire logic io_clk,
	input wire logic sample_invert,
	input wire logic update_invert,
	input wire logic cs_n,
	input wire logic reset,
	input wire logic data_in,
	input wire logic [OUT_W-1:0] tx_word,
	output logic [IN_W-1:0] rx_word,
	output logic rx_toggle,
	output logic data_out
);
	localparam int IC_W = $clog2(IN_W + 1);
	localparam int OC_W = $clog2(OUT_W + 1);
	localparam logic [IC_W-1:0] IN_LAST = IC_W'(IN_W - 1);
	localparam logic [OC_W-1:0] OUT_END = OC_W'(OUT_W);

	typedef struct packed {
		logic [IN_W-1:0] shift;
		logic [IC_W-1:0] cnt;
	} in_state_s;

	typedef struct packed {
		logic [IN_W-1:0] word;
		logic toggle;
	} rx_state_s;

	logic in_clk;
	logic out_clk;
	in_state_s in_q;
	in_state_s in_d;
	rx_state_s rx_q;
	rx_state_s rx_d;
	logic [OC_W-1:0] idx_q;
	logic [OC_W-1:0] idx_d;

	// ----------------------------------------------------------------
	// Edge selection
	// ----------------------------------------------------------------
	// Only the serial clock ever clocks these flops; an inverted copy moves
	// sampling by half a period, giving the host extra data setup time.
	assign in_clk = io_clk ^ sample_invert; // see RULE_01 see RULE_02 see RULE_03
	assign out_clk = io_clk ^ update_invert; // see RULE_05 see RULE_06

	// ----------------------------------------------------------------
	// Input shifter
	// ----------------------------------------------------------------
	always_comb begin
		in_d = in_q;
		rx_d = rx_q;
		in_d.shift = {in_q.shift[IN_W-2:0], data_in};
		if (in_q.cnt == IN_LAST) begin
			in_d.cnt = '0;
			rx_d.word = {in_q.shift[IN_W-2:0], data_in};
			rx_d.toggle = ~rx_q.toggle;
		end else begin
			in_d.cnt = in_q.cnt + IC_W'(1);
		end
	end

	always_ff @(posedge in_clk or posedge cs_n) begin
		if (cs_n) begin
			in_q <= '0;
		end else begin
			in_q <= in_d;
		end
	end

	always_ff @(posedge in_clk or posedge reset) begin
		if (reset) begin
			rx_q <= '0;
		end else if (!cs_n) begin
			rx_q <= rx_d;
		end
	end

	// ----------------------------------------------------------------
	// Output shifter
	// ----------------------------------------------------------------
	// The first bit is presented as soon as chip select falls; later bits move
	// on the update edge, which equals the sample edge when the invert pin is low.
	always_comb begin
		idx_d = (idx_q == OUT_END) ? idx_q : idx_q + OC_W'(1);
	end

	always_ff @(posedge out_clk or posedge cs_n) begin
		if (cs_n) begin
			idx_q <= '0;
		end else begin
			idx_q <= idx_d; // see RULE_04
		end
	end

	assign data_out = (idx_q < OUT_END) ? tx_word[OUT_W - 1 - 32'(idx_q)] : 1'b0;
	assign rx_word = rx_q.word;
	assign rx_toggle = rx_q.toggle;
endmodule
`default_nettype wire

// >>> test/edge_select_asserts.sv
// Purpose: Timing checks on the serial clock edge selection block.
// Assumes: Link clock edges never coincide with sys_clk rising edges.
// Notes: Link activity is judged through sys_clk samples.
`timescale 1ns/1ns
`default_nettype none
module edge_select_asserts #(parameter int IN_W = 4, parameter int OUT_W = 10) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic io_clk,
	input wire logic cs_n,
	input wire logic frame_sync,
	input wire logic clock_invert_pin,
	input wire logic data_out,
	input wire logic [IN_W-1:0] rx_word,
	input wire logic rx_valid,
	input wire logic microprocessor_mode,
	input wire logic sample_on_falling
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	AST_MODE_TAKE: assert property ($fell(cs_n) |-> ##[3:4] microprocessor_mode == $past(frame_sync, 3))
		else $error("mode differs from frame sync at select");
	AST_MODE_HOLD: assert property (!cs_n [*8] |-> $stable(microprocessor_mode))
		else $error("mode moved inside a frame");
	AST_EDGE_SEL: assert property ((!cs_n && $stable(clock_invert_pin)) [*8] |-> sample_on_falling == (microprocessor_mode ^ clock_invert_pin))
		else $error("wrong input sampling edge");
	AST_OUT_MP: assert property (!cs_n [*8] ##0 (microprocessor_mode && $changed(data_out)) |-> $fell(io_clk))
		else $error("output moved off a falling edge");
	AST_OUT_DSP: assert property (!cs_n [*8] ##0 (!microprocessor_mode && $changed(data_out)) |-> $rose(io_clk))
		else $error("output moved off a rising edge");
	AST_OUT_SAMPLE: assert property (!cs_n [*8] ##0 (!clock_invert_pin && $changed(data_out)) |-> sample_on_falling == $fell(io_clk))
		else $error("output edge differs from sampling edge");
	AST_RX_PULSE: assert property (rx_valid |=> !rx_valid)
		else $error("word strobe longer than one cycle");
	AST_RX_WORD: assert property ($changed(rx_word) |-> rx_valid)
		else $error("word changed without strobe");
endmodule
bind serial_clock_edge_select edge_select_asserts #(.IN_W(IN_W), .OUT_W(OUT_W)) u_asserts (.*);
`default_nettype wire

// >>> test/host_port.sv
// Purpose: Host serial port driving one frame per call.
// Assumes: The clock idles low and only runs inside frames.
// Notes: Input bits change on the edge the device does not sample.
`timescale 1ns/1ns
`default_nettype none
module host_port (
	output logic io_clk,
	output logic cs_n,
	output logic frame_sync,
	output logic data_in,
	input wire logic data_out
);
	initial begin
		io_clk = 0;
		cs_n = 1;
		frame_sync = 1;
		data_in = 0;
	end
	task automatic frame(input logic mp, input logic sf, input logic [11:0] d, output logic [11:0] q);
		#1 frame_sync = 1;
		#41 frame_sync = mp;
		#41 cs_n = 0;
		data_in = d[11];
		#60 frame_sync = !mp;
		for (int k = 0; k < 12; k++) begin
			#15 q[11-k] = data_out;
			io_clk = 1;
			if (sf && k > 0) data_in = d[11-k];
			#15 io_clk = 0;
			if (!sf && k < 11) data_in = d[10-k];
		end
		#80 cs_n = 1;
		// A released line must not keep its last bit, or stale data could pass.
		data_in = !data_in;
	endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Purpose: Random and corner frames through the edge selection block.
// Assumes: The host model owns every link pin.
// Notes: Output bits are compared in both modes, read just before each rising edge.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import edge_select_pkg::*;
	logic sys_clk = 0;
	logic reset = 1;
	logic clock_invert_pin = INV_RESET;
	logic [OUT_W_DEF-1:0] tx_word = '0;
	logic io_clk, cs_n, frame_sync, data_in, data_out, data_out_en, rx_valid;
	logic microprocessor_mode, sample_on_falling;
	logic [IN_W_DEF-1:0] rx_word;
	logic [11:0] q;
	int fail_count = 0;
	int n_checks = 0;
	int seed = 32'h7a9c;
	always #5 sys_clk = !sys_clk;
	serial_clock_edge_select u_dut (.*);
	host_port u_host (.*);
	function automatic logic fall_edge(input logic mp, input logic pin);
		return mp ^ pin;
	endfunction
	task automatic check(input string s, input logic [11:0] e, input logic [11:0] g);
		n_checks++;
		if (e !== g) begin
			$display("mismatch %s expected %h seen %h", s, e, g);
			fail_count++;
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#60000;
		fail_count++;
		results();
	end
	initial begin
		logic mp;
		logic [11:0] d;
		repeat (12) @(posedge sys_clk);
		reset <= 0;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < 24; i++) begin
			mp = i < 4 ? i[0] : 1'($random(seed));
			d = i < 4 ? 12'h5a6 : 12'($random(seed));
			clock_invert_pin <= i < 4 ? i[1] : 1'($random(seed));
			tx_word <= 10'($random(seed));
			@(posedge sys_clk);
			u_host.frame(mp, fall_edge(mp, clock_invert_pin), d, q);
			repeat (8) @(posedge sys_clk);
			check("mode", 12'(mp), 12'(microprocessor_mode));
			check("edge", 12'(fall_edge(mp, clock_invert_pin)), 12'(sample_on_falling));
			check("rx_word", 12'(d[3:0]), 12'(rx_word));
			check("tx_bits", {tx_word, 2'b00}, q);
			check("data_out_en", 12'(0), 12'(data_out_en));
			$display("frame %0d done", i);
		end
		results();
	end
endmodule
`default_nettype wire
